//--- rtl/cig_pkg.sv
// package for the processor core integration glue.
// assumes one 40 MHz system clock and an active-low asynchronous reset.
package cig_pkg;

  // core configuration
  localparam int NUM_IRQ        = 32;
  localparam int PRIO_BITS      = 3;
  localparam int PRIO_LSB       = 5;
  localparam int NUM_SYS_PRIO   = 12;
  localparam int FPB_LIT_CMP    = 2;
  localparam int FPB_INSTR_CMP  = 6;
  localparam int CLK_SYS_HZ     = 40_000_000;

  // interrupt controller type field: count of 32-line groups minus one
  localparam logic [4:0] INT_LINE_COUNT = 5'(NUM_IRQ / 32 - 1);

  // register byte offsets
  localparam logic [7:0] OFF_CTRL       = 8'h00;
  localparam logic [7:0] OFF_STATUS     = 8'h04;
  localparam logic [7:0] OFF_INT_TYPE   = 8'h08;
  localparam logic [7:0] OFF_AUX_FAULT  = 8'h0C;
  localparam logic [7:0] OFF_EVT_STATUS = 8'h10;
  localparam logic [7:0] OFF_EVT_CLEAR  = 8'h14;
  localparam logic [7:0] OFF_EVT_ENABLE = 8'h18;
  localparam logic [7:0] OFF_IRQ_PRIO   = 8'h20;
  localparam logic [7:0] OFF_SYS_PRIO   = 8'h40;
  localparam int         IRQ_PRIO_WORDS = 8;
  localparam int         SYS_PRIO_WORDS = 3;

  // field positions
  localparam int CTRL_SLEEP_EXIT_BIT  = 0;
  localparam int STAT_SINGLE_BOOT_BIT = 1 - 1;
  localparam int STAT_SLEEP_BIT       = 1;
  localparam int NUM_EVT              = 2;
  localparam int EVT_SLEEP_ENTRY      = 0;
  localparam int EVT_WAKE             = 1;

  // values after reset and counts
  localparam logic [31:0] RDATA_RESET      = 32'h0000_0000;
  localparam logic [31:0] AUX_FAULT_VALUE  = 32'h0000_0000;
  localparam logic [3:0]  SYS_RST_HOLD_CYC = 4'hC;

endpackage

//--- rtl/cig_ctl_if.sv
// carrier between the glue top and its event and boot helpers.
// assumes all signals live in the system clock domain.
interface cig_ctl_if;
  logic [cig_pkg::NUM_EVT-1:0] evt_set;
  logic                        clr_wr;
  logic [cig_pkg::NUM_EVT-1:0] clr_data;
  logic                        en_wr;
  logic [cig_pkg::NUM_EVT-1:0] en_data;
  logic [cig_pkg::NUM_EVT-1:0] status;
  logic [cig_pkg::NUM_EVT-1:0] en;
  logic                        irq;
  logic                        boot_pin;
  logic                        single_boot;
  logic                        boot_done;

  modport top_side (
    output evt_set, clr_wr, clr_data, en_wr, en_data, boot_pin,
    input  status, en, irq, single_boot, boot_done
  );
  modport evt_side (
    input  evt_set, clr_wr, clr_data, en_wr, en_data,
    output status, en, irq
  );
  modport boot_side (
    input  boot_pin,
    output single_boot, boot_done
  );
endinterface

//--- rtl/cig_evt.sv
// sticky event status with write-one-to-clear and an enable mask.
// assumes clear and enable writes are single-cycle strobes.
module cig_evt (
  input  wire logic     clk,
  input  wire logic     rst_n,
  cig_ctl_if.evt_side   ctl
);
  typedef struct packed {
    logic [cig_pkg::NUM_EVT-1:0] status;
    logic [cig_pkg::NUM_EVT-1:0] en;
  } cig_evt_st_t;

  cig_evt_st_t st;
  cig_evt_st_t next_st;

  always_comb begin
    next_st = st;
    // a new event in the clearing cycle survives the clear
    if (ctl.clr_wr) begin
      next_st.status = st.status & ~ctl.clr_data;
    end
    next_st.status = next_st.status | ctl.evt_set;
    if (ctl.en_wr) begin
      next_st.en = ctl.en_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign ctl.status = st.status;
  assign ctl.en     = st.en;
  assign ctl.irq    = |(st.status & st.en);
endmodule

//--- rtl/cig_boot.sv
// catches the boot-select level on the first edge after reset release.
// assumes the pin is stable around reset release.
module cig_boot (
  input  wire logic     clk,
  input  wire logic     rst_n,
  cig_ctl_if.boot_side  ctl
);
  typedef struct packed {
    logic done;
    logic single;
  } cig_boot_st_t;

  cig_boot_st_t st;
  cig_boot_st_t next_st;

  always_comb begin
    next_st = st;
    if (!st.done) begin
      next_st.done   = 1'b1;
      next_st.single = !ctl.boot_pin;
    end
  end

  // the pin is taken by a clocked edge, never by the reset itself
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign ctl.single_boot = st.single;
  assign ctl.boot_done   = st.done;

  property p_boot_sample;
    @(posedge clk) disable iff (!rst_n)
    // the edge that releases reset still sees the flop held, so start late
    rst_n && !st.done |=>
      (st.done && st.single == !$past(ctl.boot_pin));
  endproperty
  a_boot_sample: assert property (p_boot_sample)
    else $error("boot select not caught at reset release");
  c_single_boot: cover property (@(posedge clk) st.done && st.single);
endmodule

//--- rtl/cig_top.sv
// glue that joins the 32-bit processor core to the rest of the chip.
// assumes an Avalon-MM master on the system clock and a core whose
// sleep, reset, core_stuck_indication and event signals are synchronous to it.
module cig_top #(
  parameter int NUM_IRQ   = cig_pkg::NUM_IRQ,
  parameter int PRIO_BITS = cig_pkg::PRIO_BITS
) (
  input  wire logic                               CLK_SYS,
  input  wire logic                               RESETN,
  input  wire logic [7:0]                         AVS_ADDRESS,
  input  wire logic                               AVS_READ,
  input  wire logic                               AVS_WRITE,
  input  wire logic [31:0]                        AVS_WRITEDATA,
  input  wire logic [3:0]                         AVS_BYTEENABLE,
  output logic      [31:0]                        AVS_READDATA,
  output logic                                    AVS_WAITREQUEST,
  input  wire logic [NUM_IRQ-1:0]                 IRQ_IN,
  output logic      [NUM_IRQ-1:0]                 CORE_IRQ,
  output logic      [NUM_IRQ-1:0][PRIO_BITS-1:0]  CORE_IRQ_PRIO,
  output logic [cig_pkg::NUM_SYS_PRIO-1:0][PRIO_BITS-1:0] CORE_SYS_PRIO,
  output logic      [3:0]                         CFG_PRIO_BITS,
  output logic      [3:0]                         CFG_FPB_LIT_CMP,
  output logic      [3:0]                         CFG_FPB_INSTR_CMP,
  input  wire logic                               CORE_SYSTEM_RESET_REQUEST,
  output logic                                    SYS_RESET_N,
  input  wire logic                               CORE_STUCK_INDICATION,
  input  wire logic                               CORE_EVENT_OUT,
  output logic                                    CORE_EVENT_IN,
  input  wire logic                               WAIT_INTERRUPT_INSTRUCTION,
  input  wire logic                               HANDLER_EXIT,
  input  wire logic                               DEEP_SLEEP_REQUEST,
  output logic                                    CORE_SLEEP_INDICATION,
  input  wire logic                               DCODE_EXCL_REQ,
  output logic                                    DCODE_EXCL_OKAY,
  input  wire logic                               BOOT_PIN,
  output logic                                    SINGLE_BOOT,
  output logic                                    IRQ
);

  localparam logic [5:0] W_CTRL   = cig_pkg::OFF_CTRL[7:2];
  localparam logic [5:0] W_STATUS = cig_pkg::OFF_STATUS[7:2];
  localparam logic [5:0] W_TYPE   = cig_pkg::OFF_INT_TYPE[7:2];
  localparam logic [5:0] W_AUX    = cig_pkg::OFF_AUX_FAULT[7:2];
  localparam logic [5:0] W_EVT_ST = cig_pkg::OFF_EVT_STATUS[7:2];
  localparam logic [5:0] W_EVT_CL = cig_pkg::OFF_EVT_CLEAR[7:2];
  localparam logic [5:0] W_EVT_EN = cig_pkg::OFF_EVT_ENABLE[7:2];
  localparam logic [5:0] W_IPRIO  = cig_pkg::OFF_IRQ_PRIO[7:2];
  localparam logic [5:0] W_SPRIO  = cig_pkg::OFF_SYS_PRIO[7:2];

  typedef logic [3:0][PRIO_BITS-1:0] cig_prio4_t;

  typedef struct packed {
    logic                                           ack;
    logic [31:0]                                    rdata;
    logic [NUM_IRQ-1:0]                             core_irq;
    logic [NUM_IRQ-1:0][PRIO_BITS-1:0]              prio;
    logic [cig_pkg::NUM_SYS_PRIO-1:0][PRIO_BITS-1:0] sys_prio;
    logic                                           sleep_exit_en;
    logic                                           sleep;
    logic [3:0]                                     rst_cnt;
    logic                                           sys_rst_n;
  } cig_top_st_t;

  cig_top_st_t st;
  cig_top_st_t next_st;
  cig_ctl_if   ctl ();

  logic       req;
  logic       take;
  logic [5:0] word;

  // four priority fields packed into the top bits of each byte
  function automatic logic [31:0] prio_word(input cig_prio4_t f);
    logic [31:0] w;
    w = '0;
    for (int i = 0; i < 4; i++) begin
      w[i*8+cig_pkg::PRIO_LSB +: PRIO_BITS] = f[i];
    end
    return w;
  endfunction

  // byte-lane write of one field; the low bits of the byte are dropped
  function automatic logic [PRIO_BITS-1:0] prio_merge(
    input logic [PRIO_BITS-1:0] old,
    input logic [7:0]           data,
    input logic                 lane
  );
    return lane ? data[cig_pkg::PRIO_LSB +: PRIO_BITS] : old;
  endfunction

  cig_evt u_evt (
    .clk   (CLK_SYS),
    .rst_n (RESETN),
    .ctl   (ctl.evt_side)
  );

  cig_boot u_boot (
    .clk   (CLK_SYS),
    .rst_n (RESETN),
    .ctl   (ctl.boot_side)
  );

  // one wait state: the request is seen, then taken on the next edge
  assign req             = AVS_READ || AVS_WRITE;
  assign take            = req && st.ack;
  assign word            = AVS_ADDRESS[7:2];
  assign AVS_WAITREQUEST = req && !st.ack;
  assign ctl.boot_pin    = BOOT_PIN;

  always_comb begin
    logic [31:0] rd;
    rd                 = '0;
    next_st            = st;
    next_st.ack        = req && !st.ack;
    next_st.core_irq   = IRQ_IN;
    ctl.clr_wr         = 1'b0;
    ctl.clr_data       = AVS_WRITEDATA[cig_pkg::NUM_EVT-1:0];
    ctl.en_wr          = 1'b0;
    ctl.en_data        = AVS_WRITEDATA[cig_pkg::NUM_EVT-1:0];

    // read mux; unmapped words read as zero and ignore writes
    unique case (word)
      W_CTRL: begin
        rd[cig_pkg::CTRL_SLEEP_EXIT_BIT] = st.sleep_exit_en;
      end
      W_STATUS: begin
        rd[cig_pkg::STAT_SINGLE_BOOT_BIT] = ctl.single_boot;
        rd[cig_pkg::STAT_SLEEP_BIT]       = st.sleep;
      end
      W_TYPE: begin
        rd[4:0] = cig_pkg::INT_LINE_COUNT;
      end
      W_AUX: begin
        rd = cig_pkg::AUX_FAULT_VALUE;
      end
      W_EVT_ST: begin
        rd[cig_pkg::NUM_EVT-1:0] = ctl.status;
      end
      W_EVT_EN: begin
        rd[cig_pkg::NUM_EVT-1:0] = ctl.en;
      end
      default: begin
        rd = '0;
      end
    endcase

    // three implemented bits per interrupt field
    for (int i = 0; i < cig_pkg::IRQ_PRIO_WORDS; i++) begin
      if (word == W_IPRIO + 6'(i)) begin
        rd = prio_word(st.prio[4*i +: 4]);
        if (take && AVS_WRITE) begin
          for (int j = 0; j < 4; j++) begin
            next_st.prio[4*i+j] = prio_merge(st.prio[4*i+j],
              AVS_WRITEDATA[8*j +: 8], AVS_BYTEENABLE[j]);
          end
        end
      end
    end
    for (int i = 0; i < cig_pkg::SYS_PRIO_WORDS; i++) begin
      if (word == W_SPRIO + 6'(i)) begin
        rd = prio_word(st.sys_prio[4*i +: 4]);
        if (take && AVS_WRITE) begin
          for (int j = 0; j < 4; j++) begin
            next_st.sys_prio[4*i+j] = prio_merge(st.sys_prio[4*i+j],
              AVS_WRITEDATA[8*j +: 8], AVS_BYTEENABLE[j]);
          end
        end
      end
    end

    if (AVS_READ && !st.ack) begin
      next_st.rdata = rd;
    end

    if (take && AVS_WRITE && AVS_BYTEENABLE[0]) begin
      if (word == W_CTRL) begin
        next_st.sleep_exit_en =
          AVS_WRITEDATA[cig_pkg::CTRL_SLEEP_EXIT_BIT];
      end
      ctl.clr_wr = (word == W_EVT_CL);
      ctl.en_wr  = (word == W_EVT_EN);
    end

    // a pending interrupt wakes the core; deep sleep is not looked at
    if (|IRQ_IN) begin
      next_st.sleep = 1'b0;
    end else if (WAIT_INTERRUPT_INSTRUCTION ||
                 (HANDLER_EXIT && st.sleep_exit_en)) begin
      next_st.sleep = 1'b1;
    end
    ctl.evt_set                          = '0;
    ctl.evt_set[cig_pkg::EVT_SLEEP_ENTRY] = !st.sleep && next_st.sleep;
    ctl.evt_set[cig_pkg::EVT_WAKE]        = st.sleep && !next_st.sleep;

    // only the reset request counts; the stuck output never resets
    if (st.rst_cnt != 4'h0) begin
      next_st.rst_cnt = st.rst_cnt - 4'h1;
    end else if (CORE_SYSTEM_RESET_REQUEST) begin
      next_st.rst_cnt = cig_pkg::SYS_RST_HOLD_CYC;
    end
    next_st.sys_rst_n = (next_st.rst_cnt == 4'h0);
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      st           <= '0;
      st.rdata     <= cig_pkg::RDATA_RESET;
      st.sys_rst_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign AVS_READDATA          = st.rdata;
  assign CORE_IRQ              = st.core_irq;
  assign CORE_IRQ_PRIO         = st.prio;
  assign CORE_SYS_PRIO         = st.sys_prio;
  assign CORE_SLEEP_INDICATION = st.sleep;
  assign SYS_RESET_N           = st.sys_rst_n;
  assign SINGLE_BOOT           = ctl.single_boot;
  assign IRQ                   = ctl.irq;
  assign CFG_PRIO_BITS         = 4'(PRIO_BITS);
  assign CFG_FPB_LIT_CMP       = 4'(cig_pkg::FPB_LIT_CMP);
  assign CFG_FPB_INSTR_CMP     = 4'(cig_pkg::FPB_INSTR_CMP);
  // events are not used: the input is held low, the output has no load
  assign CORE_EVENT_IN         = 1'b0;
  // no exclusive monitor, so an exclusive access never reports success
  assign DCODE_EXCL_OKAY       = 1'b0;

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESETN);

  property p_irq_fwd;
    ##1 CORE_IRQ == $past(IRQ_IN) && $bits(CORE_IRQ) == 32;
  endproperty
  a_irq_fwd: assert property (p_irq_fwd)
    else $error("interrupt inputs not forwarded");

  property p_int_type;
    AVS_READ && !AVS_WAITREQUEST && word == W_TYPE |->
      AVS_READDATA[4:0] == 5'h00;
  endproperty
  a_int_type: assert property (p_int_type)
    else $error("interrupt line count field not zero");

  property p_prio_keep;
    AVS_WRITE && !AVS_WAITREQUEST && word == W_IPRIO &&
      AVS_BYTEENABLE[0] |=> CORE_IRQ_PRIO[0] == $past(AVS_WRITEDATA[7:5]);
  endproperty
  a_prio_keep: assert property (p_prio_keep)
    else $error("priority field not written");

  property p_prio_low;
    AVS_READ && !AVS_WAITREQUEST && word >= W_IPRIO |->
      (AVS_READDATA & 32'h1F1F_1F1F) == 32'h0000_0000;
  endproperty
  a_prio_low: assert property (p_prio_low)
    else $error("priority low bits not zero");

  property p_sys_reset;
    CORE_SYSTEM_RESET_REQUEST && st.rst_cnt == 4'h0 |=>
      !SYS_RESET_N [*8];
  endproperty
  a_sys_reset: assert property (p_sys_reset)
    else $error("reset request gave no system reset");

  property p_stuck_ignored;
    CORE_STUCK_INDICATION && !CORE_SYSTEM_RESET_REQUEST &&
      st.rst_cnt == 4'h0 |=> SYS_RESET_N;
  endproperty
  a_stuck_ignored: assert property (p_stuck_ignored)
    else $error("stuck indication caused a reset");

  property p_aux_zero;
    AVS_READ && !AVS_WAITREQUEST && word == W_AUX |->
      AVS_READDATA == 32'h0000_0000;
  endproperty
  a_aux_zero: assert property (p_aux_zero)
    else $error("auxiliary fault status not zero");

  property p_event_low;
    CORE_EVENT_OUT || !CORE_EVENT_OUT |-> !CORE_EVENT_IN;
  endproperty
  a_event_low: assert property (p_event_low)
    else $error("event input driven");

  property p_sleep_wfi;
    WAIT_INTERRUPT_INSTRUCTION && IRQ_IN == '0 |=>
      CORE_SLEEP_INDICATION;
  endproperty
  a_sleep_wfi: assert property (p_sleep_wfi)
    else $error("no sleep after wait-for-interrupt");

  property p_deep_ignored;
    !WAIT_INTERRUPT_INSTRUCTION && !HANDLER_EXIT &&
      IRQ_IN == '0 |=> $stable(CORE_SLEEP_INDICATION);
  endproperty
  a_deep_ignored: assert property (p_deep_ignored)
    else $error("deep-sleep output changed sleep state");

  property p_no_excl;
    DCODE_EXCL_REQ |-> !DCODE_EXCL_OKAY;
  endproperty
  a_no_excl: assert property (p_no_excl)
    else $error("exclusive access reported success");

  property p_fpb_cfg;
    ##1 CFG_FPB_LIT_CMP == 4'h2 && CFG_FPB_INSTR_CMP == 4'h6;
  endproperty
  a_fpb_cfg: assert property (p_fpb_cfg)
    else $error("breakpoint comparator counts wrong");

  c_sleep_exit: cover property (HANDLER_EXIT && st.sleep_exit_en
    ##1 CORE_SLEEP_INDICATION);
  c_sys_reset: cover property ($fell(SYS_RESET_N));
  c_irq: cover property ($rose(IRQ));
endmodule

//--- verif/cig_core_model.sv
// behavioural model of the processor core facing the glue.
// assumes its tasks are called just after a rising clock edge.
module cig_core_model (
  input  wire logic clk,
  output logic      wait_interrupt_instruction,
  output logic      handler_exit,
  output logic      reset_req,
  output logic      stuck,
  output logic      event_out,
  output logic      deep_sleep,
  output logic      excl_req
);
  timeunit 1ns;
  timeprecision 1ps;

  // software never sets the deep-sleep control bit
  assign deep_sleep = 1'b0;

  initial begin
    wait_interrupt_instruction = 1'b0;
    handler_exit = 1'b0;
    reset_req = 1'b0;
    stuck = 1'b0;
    event_out = 1'b0;
    excl_req = 1'b0;
  end

  // toggles freely so that any use of it by the glue would show
  always @(posedge clk) begin
    event_out <= ~event_out;
  end

  // raises one core output for n cycles, then drops it
  task automatic pulse(input int sel, input int n);
    for (int i = 0; i <= n; i++) begin
      case (sel)
        0: wait_interrupt_instruction <= (i < n);
        1: handler_exit <= (i < n);
        2: reset_req <= (i < n);
        3: stuck <= (i < n);
        default: excl_req <= (i < n);
      endcase
      if (i < n) begin
        @(posedge clk);
      end
    end
  endtask
endmodule

//--- verif/testbench.sv
// self-checking bench for the core integration glue.
// assumes the glue answers each bus request after one wait state.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic              clk_sys = 1'b0;
  logic              resetn = 1'b0;
  logic              avs_read = 1'b0;
  logic              avs_write = 1'b0;
  logic [7:0]        avs_address = 8'h00;
  logic [31:0]       avs_writedata = 32'h0000_0000;
  logic [3:0]        avs_byteenable = 4'hF;
  logic [31:0]       irq_in = 32'h0000_0000;
  logic              boot_pin = 1'b0;
  logic [31:0]       avs_readdata;
  logic              avs_waitrequest;
  logic [31:0]       core_irq;
  logic [31:0][2:0]  core_irq_prio;
  logic [11:0][2:0]  core_sys_prio;
  logic [3:0]        cfg_prio_bits;
  logic [3:0]        cfg_lit;
  logic [3:0]        cfg_instr;
  logic              sys_reset_n;
  logic              core_event_in;
  logic              sleep;
  logic              excl_okay;
  logic              single_boot;
  logic              irq;
  logic              wait_interrupt_instruction;
  logic              hexit;
  logic              rst_req;
  logic              stuck;
  logic              evt_out;
  logic              deep_sleep;
  logic              excl_req;
  int                fails = 0;
  int                checked = 0;
  logic [31:0]       rd_q[$];

  always #12.5 clk_sys = ~clk_sys;

  cig_top cig_top_i (
    .CLK_SYS(clk_sys), .RESETN(resetn), .AVS_ADDRESS(avs_address),
    .AVS_READ(avs_read), .AVS_WRITE(avs_write),
    .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable),
    .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
    .IRQ_IN(irq_in), .CORE_IRQ(core_irq), .CORE_IRQ_PRIO(core_irq_prio),
    .CORE_SYS_PRIO(core_sys_prio), .CFG_PRIO_BITS(cfg_prio_bits),
    .CFG_FPB_LIT_CMP(cfg_lit), .CFG_FPB_INSTR_CMP(cfg_instr),
    .CORE_SYSTEM_RESET_REQUEST(rst_req), .SYS_RESET_N(sys_reset_n),
    .CORE_STUCK_INDICATION(stuck), .CORE_EVENT_OUT(evt_out),
    .CORE_EVENT_IN(core_event_in), .WAIT_INTERRUPT_INSTRUCTION(wait_interrupt_instruction),
    .HANDLER_EXIT(hexit), .DEEP_SLEEP_REQUEST(deep_sleep),
    .CORE_SLEEP_INDICATION(sleep), .DCODE_EXCL_REQ(excl_req),
    .DCODE_EXCL_OKAY(excl_okay), .BOOT_PIN(boot_pin),
    .SINGLE_BOOT(single_boot), .IRQ(irq)
  );

  cig_core_model cig_core_model_i (
    .clk(clk_sys), .wait_interrupt_instruction(wait_interrupt_instruction), .handler_exit(hexit), .reset_req(rst_req),
    .stuck(stuck), .event_out(evt_out), .deep_sleep(deep_sleep),
    .excl_req(excl_req)
  );

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // read results are judged here, in the order the reads were issued
  always @(posedge clk_sys) begin
    chk("event input", 32'h0, 32'(core_event_in));
    if (excl_req === 1'b1) begin
      chk("exclusive okay", 32'h0, 32'(excl_okay));
    end
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      chk("read data", rd_q.pop_front(), avs_readdata);
    end
  end

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) begin
      fails++;
      print_verdict();
    end else begin
      @(posedge clk_sys);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    bus(1'b0, a, 32'h0000_0000, 4'hF);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask

  task automatic sleep_is(input logic v);
    @(negedge clk_sys);
    chk("sleep", 32'(v), 32'(sleep));
    @(posedge clk_sys);
  endtask

  task automatic wake();
    irq_in <= 32'h0000_0008;
    @(posedge clk_sys);
    irq_in <= 32'h0000_0000;
    @(posedge clk_sys);
    sleep_is(1'b0);
  endtask

  task automatic do_reset(input logic bp);
    boot_pin <= bp;
    resetn <= 1'b0;
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk("single boot", 32'(!bp), 32'(single_boot));
    @(posedge clk_sys);
  endtask

  // counts cycles of system reset while the core does something
  task automatic count_low(output int n);
    n = 0;
    repeat (30) begin
      @(negedge clk_sys);
      if (sys_reset_n === 1'b0) n++;
    end
    @(posedge clk_sys);
  endtask

  initial begin
    logic [31:0] d;
    int          n;
    void'($urandom(20));
    @(posedge clk_sys);
    do_reset(1'b0);
    chk("prio bits", 32'h3, 32'(cfg_prio_bits));
    chk("literal cmp", 32'h2, 32'(cfg_lit));
    chk("instr cmp", 32'h6, 32'(cfg_instr));
    rd(cig_pkg::OFF_INT_TYPE, 32'h0000_0000);
    rd(cig_pkg::OFF_AUX_FAULT, 32'h0000_0000);
    rd(8'hFC, 32'h0000_0000);
    rd(cig_pkg::OFF_STATUS, 32'h0000_0001);
    for (int i = 0; i < 8; i++) begin
      d = $urandom();
      irq_in <= d;
      @(posedge clk_sys);
      @(negedge clk_sys);
      chk("core irq", d, core_irq);
      @(posedge clk_sys);
    end
    irq_in <= 32'h0000_0000;
    @(posedge clk_sys);
    wr(cig_pkg::OFF_EVT_CLEAR, 32'h0000_0003);
    rd(cig_pkg::OFF_EVT_STATUS, 32'h0000_0000);
    for (int k = 0; k < 8; k++) begin
      d = $urandom();
      wr(cig_pkg::OFF_IRQ_PRIO + 8'(4 * k), d);
      rd(cig_pkg::OFF_IRQ_PRIO + 8'(4 * k), d & 32'hE0E0_E0E0);
      for (int j = 0; j < 4; j++) begin
        chk("irq prio", 32'(d[8*j+5 +: 3]),
            32'(core_irq_prio[4*k+j]));
      end
    end
    bus(1'b1, cig_pkg::OFF_IRQ_PRIO + 8'h1C, 32'hFFFF_FFFF, 4'h2);
    rd(cig_pkg::OFF_IRQ_PRIO + 8'h1C,
       (d | 32'h0000_FF00) & 32'hE0E0_E0E0);
    wr(cig_pkg::OFF_SYS_PRIO, 32'hFFFF_FFFF);
    rd(cig_pkg::OFF_SYS_PRIO, 32'hE0E0_E0E0);
    chk("sys prio", 32'h7, 32'(core_sys_prio[3]));
    wr(cig_pkg::OFF_EVT_ENABLE, 32'h0000_0003);
    cig_core_model_i.pulse(0, 1);
    sleep_is(1'b1);
    chk("irq", 32'h1, 32'(irq));
    rd(cig_pkg::OFF_STATUS, 32'h0000_0003);
    rd(cig_pkg::OFF_EVT_STATUS, 32'h0000_0001);
    wr(cig_pkg::OFF_EVT_CLEAR, 32'h0000_0001);
    rd(cig_pkg::OFF_EVT_STATUS, 32'h0000_0000);
    chk("irq", 32'h0, 32'(irq));
    wake();
    rd(cig_pkg::OFF_EVT_STATUS, 32'h0000_0002);
    chk("irq", 32'h1, 32'(irq));
    wr(cig_pkg::OFF_EVT_ENABLE, 32'h0000_0001);
    chk("irq masked", 32'h0, 32'(irq));
    wr(cig_pkg::OFF_EVT_CLEAR, 32'h0000_0003);
    cig_core_model_i.pulse(1, 1);
    sleep_is(1'b0);
    wr(cig_pkg::OFF_CTRL, 32'h0000_0001);
    rd(cig_pkg::OFF_CTRL, 32'h0000_0001);
    cig_core_model_i.pulse(1, 1);
    sleep_is(1'b1);
    wake();
    // a held request must not stretch or restart the reset pulse
    fork
      cig_core_model_i.pulse(2, 3);
      count_low(n);
    join
    chk("reset cycles", 32'(cig_pkg::SYS_RST_HOLD_CYC), 32'(n));
    fork
      cig_core_model_i.pulse(3, 20);
      count_low(n);
    join
    chk("stuck reset", 32'h0, 32'(n));
    cig_core_model_i.pulse(4, 3);
    do_reset(1'b1);
    rd(cig_pkg::OFF_STATUS, 32'h0000_0000);
    rd(cig_pkg::OFF_CTRL, 32'h0000_0000);
    rd(cig_pkg::OFF_EVT_ENABLE, 32'h0000_0000);
    rd(cig_pkg::OFF_IRQ_PRIO, 32'h0000_0000);
    print_verdict();
  end
endmodule
